//--- rtl/dsm_adc_ctrl.v
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "dsm_ctrl_regs.vh"

// Notes on behaviour
// - start by control bit or soc input
// - completion sets status bit and done output
// - done holds until result is read
// - four selectable modes
// - result depends on last four sample periods
// - results invalid until fourth sample after switch
// - twelve bit results at full rate
// - eight bit results at doubled rate
// - one bit stream in, parallel words out
// - stream arrives via analog interface port
// - sinc4 via four integrate-dump stages
// - single mode primes three, completes on fourth
// - continuous: three conversion latency, then free running
// - multi mode re-primes and restarts automatically
// - done goes high at every published result and stays high until read
module dsm_adc_ctrl
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire aif_bit,
  input wire aif_valid,
  input wire soc,
  input wire dma_ack,
  output wire eoc,
  output wire irq,
  output wire [2:0] amux_sel
);

  // ---------------------------------------------------------------
  // state codes
  // ---------------------------------------------------------------
  localparam S_IDLE = 2'd0;
  localparam S_PRIME = 2'd1;
  localparam S_RUN = 2'd2;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [3:0] cfg_ff;
  reg [9:0] decim_ff;
  reg [2:0] mux_ff;
  reg [1:0] int_stat_ff;
  reg [1:0] int_mask_ff;
  reg done_ff;
  reg valid_ff;
  reg [15:0] result_ff;
  reg [9:0] cnt_ff;
  reg [2:0] conv_ff;
  reg [2:0] settle_ff;
  reg clr_ff;

  wire soc_rise;
  wire [31:0] raw;
  wire wr_en;
  wire rd_en;
  wire start_req;
  wire stop_req;
  wire dump;
  wire [1:0] mode;
  wire res8;
  wire [9:0] ratio;
  wire conv_end;
  wire primed;
  wire read_result;
  wire mux_wr;
  wire reprime;
  wire publish;
  wire sel_ctrl;
  wire sel_result;
  wire sel_istat;
  wire [1:0] int_set;
  wire [1:0] int_clr;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // ratio R gives sinc4 growth of R^4; shift back to the result width
  function [15:0] scale;
    input [31:0] r;
    input r8;
    begin
      if (r8)
        scale = {8'h00, r[23:16]};
      else
        scale = {4'h0, r[27:16]};
    end
  endfunction

  // ---------------------------------------------------------------
  // sub blocks
  // ---------------------------------------------------------------
  sync_edge u_soc
  (
    .pclk(pclk),
    .presetn(presetn),
    .din(soc),
    .rise(soc_rise)
  );

  sinc4_decim u_decim
  (
    .pclk(pclk),
    .presetn(presetn),
    .clr(clr_ff),
    .bit_valid(aif_valid & (state_ff != S_IDLE)),
    .bit_in(aif_bit),
    .dump(dump),
    .raw(raw)
  );

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign mode = cfg_ff[`CFG_MODE_HI:`CFG_MODE_LO];
  assign res8 = cfg_ff[`CFG_RES8] | (mode == `MODE_TURBO);
  // halving the ratio doubles the rate at lower resolution
  assign sel_ctrl = hit(paddr, `OFS_CTRL);
  assign sel_result = hit(paddr, `OFS_RESULT);
  assign sel_istat = hit(paddr, `OFS_INT_STAT);
  // a ratio of one would halve to zero and never dump
  assign ratio = res8 ? ((decim_ff[9:1] == 9'd0) ? 10'd1 : {1'b0, decim_ff[9:1]}) : decim_ff;
  assign start_req = (wr_en & sel_ctrl & pwdata[`CTRL_START]) | soc_rise;
  assign stop_req = wr_en & sel_ctrl & pwdata[`CTRL_STOP];
  assign mux_wr = wr_en & hit(paddr, `OFS_MUXSEL) & (pwdata[2:0] != mux_ff);
  assign read_result = (rd_en & sel_result) | dma_ack;
  assign dump = (state_ff != S_IDLE) & aif_valid & (cnt_ff == ratio);
  assign conv_end = dump;
  assign primed = conv_ff >= `PRIME_CONVS;
  // multi and turbo clear the decimator after every published result
  assign reprime = conv_end & primed & (mode != `MODE_SINGLE) & (mode != `MODE_CONT);
  assign amux_sel = mux_ff;

  always @*
  begin
    prdata = 32'h0000_0000;
    if (rd_en)
    begin
      if (hit(paddr, `OFS_CFG))
        prdata = {28'd0, cfg_ff};
      else if (hit(paddr, `OFS_STATUS))
        prdata = {29'd0, valid_ff, (state_ff != S_IDLE), done_ff};
      else if (hit(paddr, `OFS_RESULT))
        prdata = {16'd0, result_ff};
      else if (hit(paddr, `OFS_INT_STAT))
        prdata = {30'd0, int_stat_ff};
      else if (hit(paddr, `OFS_INT_MASK))
        prdata = {30'd0, int_mask_ff};
      else if (hit(paddr, `OFS_DECIM))
        prdata = {22'd0, decim_ff};
      else if (hit(paddr, `OFS_MUXSEL))
        prdata = {29'd0, mux_ff};
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_ff <= `CFG_RESET;
      decim_ff <= `DECIM_RESET;
      mux_ff <= 3'd0;
      int_mask_ff <= 2'b00;
    end
    else if (wr_en)
    begin
      if (hit(paddr, `OFS_CFG))
        cfg_ff <= pwdata[3:0];
      else if (hit(paddr, `OFS_DECIM))
        decim_ff <= (pwdata[9:0] == 10'd0) ? 10'd1 : pwdata[9:0];
      else if (hit(paddr, `OFS_MUXSEL))
        mux_ff <= pwdata[2:0];
      else if (hit(paddr, `OFS_INT_MASK))
        int_mask_ff <= pwdata[1:0];
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // a start while busy is ignored; only idle listens for triggers
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE:
        if (start_req & cfg_ff[`CFG_ENABLE])
          nxt_state = S_PRIME;
      S_PRIME:
        if (stop_req)
          nxt_state = S_IDLE;
        else if (conv_end & primed & (mode == `MODE_SINGLE))
          nxt_state = S_IDLE;
        else if (conv_end & primed & (mode == `MODE_CONT))
          nxt_state = S_RUN;
      S_RUN:
        if (stop_req | ~cfg_ff[`CFG_ENABLE])
          nxt_state = S_IDLE;
        else if (reprime)
          nxt_state = S_PRIME;
      default:
        nxt_state = S_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= S_IDLE;
      clr_ff <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
      // re-prime clears the pipeline so old samples cannot leak in
      clr_ff <= (nxt_state == S_IDLE) | reprime;
    end
  end

  // ---------------------------------------------------------------
  // conversion counters
  // ---------------------------------------------------------------
  // a sample that lands in the clear cycle is dropped, not counted
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff <= 10'd1;
      conv_ff <= 3'd0;
    end
    else if ((state_ff == S_IDLE) | clr_ff)
    begin
      cnt_ff <= 10'd1;
      conv_ff <= 3'd0;
    end
    else if (aif_valid)
    begin
      cnt_ff <= dump ? 10'd1 : cnt_ff + 10'd1;
      if (dump & ~primed)
        conv_ff <= conv_ff + 3'd1;
    end
  end

  // ---------------------------------------------------------------
  // result and completion
  // ---------------------------------------------------------------
  assign publish = conv_end & primed;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      result_ff <= 16'h0000;
      done_ff <= 1'b0;
    end
    else
    begin
      if (publish)
        result_ff <= scale(raw, res8);
      // set wins over a read in the same cycle
      if (publish)
        done_ff <= 1'b1;
      else if (read_result)
        done_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // settling after an input switch
  // ---------------------------------------------------------------
  // only the status bit tracks settling; results still publish meanwhile
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      settle_ff <= 3'd0;
      valid_ff <= 1'b0;
    end
    else
    begin
      if (mux_wr)
        settle_ff <= 3'd0;
      else if (publish & (settle_ff < `SETTLE_SAMPLES))
        settle_ff <= settle_ff + 3'd1;
      if (publish)
        valid_ff <= ~mux_wr & ((settle_ff + 3'd1) >= `SETTLE_SAMPLES);
      else if (mux_wr)
        valid_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  // overrun: a new result lands while the last one is still unread
  assign int_set = {publish & done_ff & ~read_result, publish};
  assign int_clr = (wr_en & sel_istat) ? pwdata[1:0] : 2'b00;

  // set wins over a clear in the same cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_stat_ff <= 2'b00;
    else
      int_stat_ff <= (int_stat_ff & ~int_clr) | int_set;
  end

  // irq is a level: it follows the sticky bits, not the events
  assign eoc = done_ff;
  assign irq = |(int_stat_ff & int_mask_ff);

endmodule

//--- rtl/dsm_ctrl_regs.vh
`ifndef DSM_CTRL_REGS_VH
`define DSM_CTRL_REGS_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFS_CTRL 12'h000
`define OFS_CFG 12'h004
`define OFS_STATUS 12'h008
`define OFS_RESULT 12'h00c
`define OFS_INT_STAT 12'h010
`define OFS_INT_MASK 12'h014
`define OFS_DECIM 12'h018
`define OFS_MUXSEL 12'h01c

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CTRL_START 0
`define CTRL_STOP 1
`define CFG_MODE_LO 0
`define CFG_MODE_HI 1
`define CFG_RES8 2
`define CFG_ENABLE 3
`define STAT_DONE 0
`define STAT_BUSY 1
`define STAT_VALID 2
`define INT_DONE 0
`define INT_OVR 1

// ---------------------------------------------------------------
// modes
// ---------------------------------------------------------------
`define MODE_SINGLE 2'd0
`define MODE_MULTI 2'd1
`define MODE_CONT 2'd2
`define MODE_TURBO 2'd3

// ---------------------------------------------------------------
// reset values and timing counts
// ---------------------------------------------------------------
`define CFG_RESET 4'h8
`define DECIM_RESET 10'd63
`define PRIME_CONVS 3'd3
`define SETTLE_SAMPLES 3'd4
`define STAGES 4
`define ACC_W 32

`endif

//--- rtl/sync_edge.v
`timescale 1ns/1ps

// ---------------------------------------------------------------
// two flop synchroniser plus rising edge detect
// ---------------------------------------------------------------
module sync_edge
(
  input wire pclk,
  input wire presetn,
  input wire din,
  output wire rise
);

  reg meta_ff;
  reg sync_ff;
  reg last_ff;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= din;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  // edge is taken on the second flop only
  assign rise = sync_ff & ~last_ff;

endmodule

//--- rtl/sinc4_decim.v
`timescale 1ns/1ps
`include "dsm_ctrl_regs.vh"

// ---------------------------------------------------------------
// fourth order integrate-and-dump cascade
// ---------------------------------------------------------------
module sinc4_decim
(
  input wire pclk,
  input wire presetn,
  input wire clr,
  input wire bit_valid,
  input wire bit_in,
  input wire dump,
  output wire [31:0] raw
);

  reg [31:0] integ_ff [0:3];
  reg [31:0] comb_ff [0:3];
  reg [31:0] out_ff;
  reg [31:0] comb_in [0:3];
  reg [31:0] stage;
  integer i;
  integer j;

  // comb chain worked out ahead of the edge, so the clocked process stays non-blocking
  always @*
  begin
    stage = integ_ff[`STAGES-1];
    for (j = 0; j < `STAGES; j = j + 1)
    begin
      comb_in[j] = stage;
      stage = stage - comb_ff[j];
    end
  end

  // modular wraparound is harmless: combs undo the integrator growth
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (i = 0; i < `STAGES; i = i + 1)
      begin
        integ_ff[i] <= 32'h0000_0000;
        comb_ff[i] <= 32'h0000_0000;
      end
      out_ff <= 32'h0000_0000;
    end
    else if (clr)
    begin
      for (i = 0; i < `STAGES; i = i + 1)
      begin
        integ_ff[i] <= 32'h0000_0000;
        comb_ff[i] <= 32'h0000_0000;
      end
      out_ff <= 32'h0000_0000;
    end
    else
    begin
      if (bit_valid)
      begin
        integ_ff[0] <= integ_ff[0] + {31'd0, bit_in};
        for (i = 1; i < `STAGES; i = i + 1)
          integ_ff[i] <= integ_ff[i] + integ_ff[i-1];
      end
      if (dump)
      begin
        for (i = 0; i < `STAGES; i = i + 1)
          comb_ff[i] <= comb_in[i];
        out_ff <= stage;
      end
    end
  end

  assign raw = out_ff;

endmodule

//--- test/mod_stream.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------
// modulator stream seen through the analog interface
// ---------------------------------------------------------------
module mod_stream
(
  input wire pclk,
  input wire presetn,
  output reg aif_bit,
  output reg aif_valid
);
  reg [3:0] lfsr_ff;
  // one sample every other cycle; bits from an lfsr so the stream never sits still
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      lfsr_ff <= 4'h1;
      aif_valid <= 1'h0;
      aif_bit <= 1'h0;
    end
    else
    begin
      aif_valid <= !aif_valid;
      lfsr_ff <= {lfsr_ff[2:0], lfsr_ff[3] ^ lfsr_ff[2]};
      aif_bit <= lfsr_ff[0];
    end
endmodule

//--- test/dsm_adc_ctrl_props.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------
// bus, done output and mux select checks
// ---------------------------------------------------------------
module dsm_adc_ctrl_props
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire aif_valid,
  input wire dma_ack,
  input wire eoc,
  input wire [2:0] amux_sel
);
  wire acc = psel && penable;
  wire rd_res = acc && !pwrite && paddr == 12'h00c;
  wire mux_wr = acc && pwrite && paddr == 12'h01c;
  default clocking
    @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_no_slverr: assert property (!pslverr)
    else $error("pslverr high");
  a_rdata_idle: assert property (!acc |-> prdata == 32'h0)
    else $error("prdata outside access");
  a_rdata_unmapped: assert property (acc && !pwrite && paddr >= 12'h020 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_eoc_holds: assert property (eoc && !rd_res && !dma_ack |=> eoc)
    else $error("done dropped without read");
  // a conversion ending in the read cycle may set done again
  a_eoc_clears: assert property ((rd_res || dma_ack) && eoc |=> !eoc || $past(aif_valid))
    else $error("done not cleared by read");
  a_mux_write: assert property (mux_wr |=> amux_sel == $past(pwdata[2:0]))
    else $error("mux select not written");
  a_mux_stable: assert property (!mux_wr |=> $stable(amux_sel))
    else $error("mux select moved");
endmodule

bind dsm_adc_ctrl dsm_adc_ctrl_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .aif_valid, .dma_ack, .eoc, .amux_sel);

//--- test/tb.sv
`timescale 1ns/1ps
`include "dsm_ctrl_regs.vh"

// ---------------------------------------------------------------
// bench
// ---------------------------------------------------------------
module tb;
  reg pclk, presetn, psel, penable, pwrite, soc, dma_ack;
  reg [11:0] paddr;
  reg [31:0] pwdata;
  wire [31:0] prdata;
  wire pready, pslverr, aif_bit, aif_valid, eoc, irq;
  wire [2:0] amux_sel;
  logic [31:0] q;
  int n, n_errors, tests_run;
  dsm_adc_ctrl u_dsm_adc_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .aif_bit, .aif_valid, .soc, .dma_ack, .eoc, .irq, .amux_sel);
  mod_stream u_mod_stream (.pclk, .presetn, .aif_bit, .aif_valid);
  initial
  begin
    pclk = 1'h0;
    forever #20 pclk = ~pclk;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task rng(input int g, input int lo, input int hi);
    tests_run++;
    if (g < lo || g > hi)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h..%h", $time, g, lo, hi);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // request stands until pready is seen high at a rising edge
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(negedge pclk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task rd(input logic [11:0] a);
    apb(1'h0, a, 32'h0);
  endtask
  // counts modulator samples until done shows
  task wait_eoc(input int lo, input int hi);
    n = 0;
    repeat (3000)
      if (eoc !== 1'h1)
      begin
        @(negedge pclk);
        n += (aif_valid === 1'h1);
      end
    rng(n, lo, hi);
  endtask
  task ack;
    @(posedge pclk);
    dma_ack <= 1'h1;
    @(posedge pclk);
    dma_ack <= 1'h0;
    @(negedge pclk);
  endtask
  task t_regs;
    rd(12'h004);
    chk(q, `CFG_RESET);
    rd(12'h018);
    chk(q, `DECIM_RESET);
    wr(12'h018, 32'h0);
    rd(12'h018);
    chk(q, 32'h1);
    wr(12'h040, 32'h5);
    rd(12'h040);
    chk(q, 32'h0);
  endtask
  task t_single;
    wr(12'h018, 32'h8);
    wr(12'h014, 32'h1);
    wr(12'h000, 32'h1);
    wait_eoc(30, 34);
    rd(12'h008);
    chk(q & 32'h1, 32'h1);
    chk(irq, 1'h1);
    rd(12'h00c);
    chk(q >> 12, 32'h0);
    chk(eoc, 1'h0);
    rd(12'h008);
    chk(q & 32'h1, 32'h0);
    wr(12'h010, 32'h1);
    chk(irq, 1'h0);
    repeat (100) @(negedge pclk);
    chk(eoc, 1'h0);
  endtask
  task t_soc;
    @(posedge pclk);
    soc <= 1'h1;
    wait_eoc(30, 35);
    ack;
    chk(eoc, 1'h0);
    repeat (100) @(negedge pclk);
    chk(eoc, 1'h0);
    @(posedge pclk);
    soc <= 1'h0;
    wr(12'h010, 32'h3);
  endtask
  task t_cont;
    wr(12'h014, 32'h0);
    wr(12'h004, 32'ha);
    wr(12'h000, 32'h1);
    wait_eoc(30, 34);
    chk(irq, 1'h0);
    ack;
    wait_eoc(5, 9);
    repeat (20) @(posedge pclk);
    rd(12'h010);
    chk(q, 32'h3);
    wr(12'h000, 32'h2);
    repeat (40) @(posedge pclk);
    ack;
    wr(12'h010, 32'h3);
  endtask
  task t_multi(input logic [1:0] m, input int p, input logic [31:0] k);
    wr(12'h004, 32'h8 | m);
    wr(12'h000, 32'h1);
    wait_eoc(4 * p - 2, 4 * p + 2);
    rd(12'h00c);
    chk(q & ~k, 32'h0);
    wait_eoc(4 * p - 4, 4 * p + 1);
    wr(12'h000, 32'h2);
    repeat (80) @(posedge pclk);
    rd(12'h00c);
    wr(12'h010, 32'h3);
  endtask
  task t_mux;
    wr(12'h01c, 32'h5);
    chk(amux_sel, 3'h5);
    rd(12'h008);
    chk(q & 32'h4, 32'h0);
  endtask
  task report_and_stop;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, soc, dma_ack} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    t_regs;
    t_single;
    t_soc;
    t_cont;
    t_multi(`MODE_MULTI, 8, 32'hfff);
    t_multi(`MODE_TURBO, 4, 32'hff);
    t_mux;
    report_and_stop;
  end
  initial
  begin
    #2000000;
    n_errors++;
    report_and_stop;
  end
endmodule
